// ===== burst_mem.sv
// Burst memory: small buffer of bytes for one transfer, registered read data
module burst_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("burst_mem depth exceeds address range");
        end
    end

    // Storage and registered read; no reset, contents are written before read
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== i2c_host_pkg.sv
// Package: constants for the two-wire register host controller
package i2c_host_pkg;
    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h57;
    localparam logic [7:0] ADDR_WRITE = 8'hAE;
    localparam logic [7:0] ADDR_READ = 8'hAF;
    localparam logic [7:0] FIFO_DATA_INDEX = 8'h07;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 50000000;
    localparam int SCL_MAX_HZ = 400000;
    // Quarter period of the serial clock, rounded up so the bus never runs faster than allowed
    localparam int QUARTER_CYCLES = (SYS_CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
    localparam int MAX_RETRIES = 3;
    localparam int MAX_BURST = 16;
endpackage

// ===== i2c_reg_host.sv
// Two-wire bus master that writes and reads the sensor register bank
// Function
// - One bit per clock, data steady while high
// - Start and stop are data edges, clock high
// - Lines idle high; stop frees bus
// - Repeated start keeps bus, begins new transfer
// - Never stop within the start's high pulse
// - Direction bit: zero write, one read
// - Address 1010111: bytes 0xAE and 0xAF
// - Master checks acknowledge, retries on failure
// - Master acks reads, nacks last, then stops
// - Write: address, index, data bytes, stop
// - Read: write index, repeated start, read address
// - Beyond FIFO register needs fresh index write
// - Clock up to 400kHz; data open drain
module i2c_reg_host #(
    parameter int QUARTER = i2c_host_pkg::QUARTER_CYCLES,
    parameter int RETRIES = i2c_host_pkg::MAX_RETRIES,
    parameter int BURST = i2c_host_pkg::MAX_BURST
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Command
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_index,
    input wire logic [4:0] cmd_len,
    output logic cmd_ready,
    // Write data, loaded before the command
    input wire logic wdata_valid,
    input wire logic [3:0] wdata_addr,
    input wire logic [7:0] wdata,
    // Read data stream
    output logic rdata_valid,
    output logic [7:0] rdata,
    // Completion
    output logic done,
    output logic nack_err,
    // Bus pins
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    initial begin
        // The retry counter is two bits wide, so a retry limit above three would be truncated to two bits
        if (QUARTER < 1 || BURST > 16 || BURST < 1 || RETRIES < 1 || RETRIES > 3) begin
            $error("i2c_reg_host: unsupported parameter values");
        end
    end

    // ------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------
    logic sda_m_r, sda_s_r;
    // Two stages before any logic reads the returned data line
    always_ff @(posedge sys_clk) begin
        sda_m_r <= sda_i;
        sda_s_r <= sda_m_r;
    end

    // ------------------------------------------------------------
    // Burst memory
    // ------------------------------------------------------------
    logic [3:0] byte_cnt_r, byte_cnt_nxt;
    logic [7:0] mem_q;
    burst_mem #(.DEPTH(16), .AW(4)) u_mem (
        .sys_clk(sys_clk),
        .wr_en(wdata_valid && cmd_ready),
        .wr_addr(wdata_addr),
        .wr_data(wdata),
        .rd_addr(byte_cnt_nxt),
        .rd_data(mem_q)
    );

    // ------------------------------------------------------------
    // Bit engine and transfer sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_RSTART, ST_STOP, ST_GAP
    } state_e;
    typedef enum logic [1:0] {PH_ADDR_W, PH_INDEX, PH_DATA, PH_ADDR_R} phase_e;

    state_e st_r, st_nxt;
    phase_e ph_r, ph_nxt;
    logic [1:0] q_r, q_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [4:0] len_r, len_nxt;
    logic rd_r, rd_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [1:0] try_r, try_nxt;
    logic scl_r, scl_nxt, sda_r, sda_nxt;
    logic ready_r, ready_nxt, rv_r, rv_nxt, done_r, done_nxt, err_r, err_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic tick_end;

    // Pick the byte shifted after an acknowledged one
    function automatic logic [7:0] next_byte(input phase_e ph, input logic rd, input logic [7:0] idx,
                                             input logic [7:0] mdat);
        case (ph)
            PH_ADDR_W: next_byte = idx;
            PH_INDEX: next_byte = rd ? i2c_host_pkg::ADDR_READ : mdat;
            default: next_byte = mdat;
        endcase
    endfunction

    assign tick_end = (tick_r == 16'(QUARTER - 1));

    // Next state: each bit spends four quarters, clock high in quarters 1 and 2
    always_comb begin
        st_nxt = st_r;
        ph_nxt = ph_r;
        q_nxt = q_r;
        tick_nxt = tick_end ? 16'h0000 : tick_r + 16'h0001;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        len_nxt = len_r;
        rd_nxt = rd_r;
        idx_nxt = idx_r;
        try_nxt = try_r;
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        ready_nxt = ready_r;
        rv_nxt = 1'b0;
        done_nxt = 1'b0;
        err_nxt = err_r;
        rdata_nxt = rdata_r;
        byte_cnt_nxt = byte_cnt_r;
        if (st_r != ST_IDLE && tick_end) begin
            q_nxt = q_r + 2'h1;
        end
        case (st_r)
            ST_IDLE: begin
                scl_nxt = 1'b1;
                sda_nxt = 1'b1;
                tick_nxt = 16'h0000;
                q_nxt = 2'h0;
                ready_nxt = 1'b1;
                if (cmd_valid && ready_r && cmd_len != 5'h00 && cmd_len <= 5'(BURST)) begin
                    ready_nxt = 1'b0;
                    rd_nxt = cmd_read;
                    idx_nxt = cmd_index;
                    len_nxt = cmd_len;
                    try_nxt = 2'h0;
                    err_nxt = 1'b0;
                    st_nxt = ST_START;
                end
            end
            ST_START: begin
                // Data falls in quarter 1 with clock high, clock falls only after quarter 2
                if (tick_end) begin
                    case (q_r)
                        2'h0: sda_nxt = 1'b0;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: scl_nxt = 1'b0;
                        default: begin
                            st_nxt = ST_BIT;
                            ph_nxt = PH_ADDR_W;
                            sh_nxt = i2c_host_pkg::ADDR_WRITE;
                            bit_nxt = 3'h7;
                            byte_cnt_nxt = 4'h0;
                        end
                    endcase
                end
            end
            ST_BIT: begin
                if (tick_end) begin
                    case (q_r)
                        2'h0: scl_nxt = 1'b1;
                        2'h1: if (ph_r == PH_DATA && rd_r) sh_nxt = {sh_r[6:0], sda_s_r};
                        2'h2: scl_nxt = 1'b0;
                        default: begin
                            if (bit_r == 3'h0) begin
                                st_nxt = ST_ACK;
                            end else begin
                                bit_nxt = bit_r - 3'h1;
                                if (!(ph_r == PH_DATA && rd_r)) sh_nxt = {sh_r[6:0], 1'b0};
                            end
                        end
                    endcase
                end
                // Data changes only while the clock is low
                if (q_r == 2'h0) begin
                    sda_nxt = (ph_r == PH_DATA && rd_r) ? 1'b1 : sh_r[7];
                end
            end
            ST_ACK: begin
                if (q_r == 2'h0) begin
                    // Ack every read byte but the last, which gets a not-acknowledge
                    sda_nxt = (ph_r == PH_DATA && rd_r) ? (len_r == 5'h01) : 1'b1;
                end
                if (tick_end) begin
                    case (q_r)
                        2'h0: scl_nxt = 1'b1;
                        2'h1: begin
                            if (ph_r == PH_DATA && rd_r) begin
                                rv_nxt = 1'b1;
                                rdata_nxt = sh_r;
                            end else if (sda_s_r) begin
                                err_nxt = 1'b1;
                            end
                        end
                        2'h2: scl_nxt = 1'b0;
                        default: begin
                            bit_nxt = 3'h7;
                            if (err_r) begin
                                st_nxt = ST_STOP;
                            end else if (ph_r == PH_ADDR_W) begin
                                ph_nxt = PH_INDEX;
                                sh_nxt = next_byte(ph_r, rd_r, idx_r, mem_q);
                                st_nxt = ST_BIT;
                            end else if (ph_r == PH_INDEX && rd_r) begin
                                st_nxt = ST_RSTART;
                            end else if (ph_r == PH_ADDR_R) begin
                                ph_nxt = PH_DATA;
                                st_nxt = ST_BIT;
                            end else if (ph_r == PH_INDEX) begin
                                // Slot 0 goes out now; point at slot 1 so the registered read is one byte ahead
                                byte_cnt_nxt = 4'h1;
                                ph_nxt = PH_DATA;
                                sh_nxt = next_byte(ph_r, rd_r, idx_r, mem_q);
                                st_nxt = ST_BIT;
                            end else if (len_r == 5'h01) begin
                                st_nxt = ST_STOP;
                            end else begin
                                len_nxt = len_r - 5'h01;
                                byte_cnt_nxt = byte_cnt_r + 4'h1;
                                sh_nxt = mem_q;
                                st_nxt = ST_BIT;
                            end
                        end
                    endcase
                end
            end
            ST_RSTART: begin
                // Release data with clock low, raise clock, then pull data low: no stop between
                if (tick_end) begin
                    case (q_r)
                        2'h0: sda_nxt = 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sda_nxt = 1'b0;
                        default: begin
                            scl_nxt = 1'b0;
                            ph_nxt = PH_ADDR_R;
                            sh_nxt = i2c_host_pkg::ADDR_READ;
                            st_nxt = ST_BIT;
                        end
                    endcase
                end
            end
            ST_STOP: begin
                // Stop comes in a clock-high pulse of its own, never the start's one
                if (tick_end) begin
                    case (q_r)
                        2'h0: sda_nxt = 1'b0;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sda_nxt = 1'b1;
                        default: st_nxt = ST_GAP;
                    endcase
                end
            end
            ST_GAP: begin
                // Bus free time before the next start or retry
                if (tick_end && q_r == 2'h3) begin
                    if (err_r && try_r != 2'(RETRIES)) begin
                        try_nxt = try_r + 2'h1;
                        err_nxt = 1'b0;
                        len_nxt = len_r;
                        st_nxt = ST_START;
                    end else begin
                        done_nxt = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // Registers; a retry restarts from the first byte but sends only the len_r bytes still left
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= ST_IDLE;
            ph_r <= PH_ADDR_W;
            q_r <= 2'h0;
            tick_r <= 16'h0000;
            bit_r <= 3'h7;
            sh_r <= 8'h00;
            len_r <= 5'h00;
            rd_r <= 1'b0;
            idx_r <= 8'h00;
            try_r <= 2'h0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            ready_r <= 1'b0;
            rv_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 8'h00;
            byte_cnt_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            q_r <= q_nxt;
            tick_r <= tick_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            len_r <= len_nxt;
            rd_r <= rd_nxt;
            idx_r <= idx_nxt;
            try_r <= try_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
            ready_r <= ready_nxt;
            rv_r <= rv_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            rdata_r <= rdata_nxt;
            byte_cnt_r <= byte_cnt_nxt;
        end
    end

    // Open-drain outputs: enable only while pulling low
    assign cmd_ready = ready_r;
    assign rdata_valid = rv_r;
    assign rdata = rdata_r;
    assign done = done_r;
    assign nack_err = err_r;
    assign scl_o = 1'b0;
    assign scl_oe = ~scl_r;
    assign sda_o = 1'b0;
    assign sda_oe = ~sda_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence clk_high_data_fall;
        scl_r && $fell(sda_r);
    endsequence

    AST_DATA_STABLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
        (scl_r && $past(scl_r) && $changed(sda_r)) |-> (st_r inside {ST_START, ST_STOP, ST_RSTART, ST_GAP}))
        else $error("data changed while clock high outside a condition");
    AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == ST_IDLE && $past(st_r) == ST_IDLE) |-> (scl_r && sda_r))
        else $error("bus not idle high");
    AST_START_FALL: assert property (@(posedge sys_clk) disable iff (rst)
        clk_high_data_fall |-> (st_r inside {ST_START, ST_RSTART}))
        else $error("unexpected start");
    AST_STOP_SEPARATE: assert property (@(posedge sys_clk) disable iff (rst)
        clk_high_data_fall |-> ##1 (!$rose(sda_r) throughout (scl_r [*2])) or ##1 !scl_r)
        else $error("stop inside start pulse");
    AST_FIRST_BYTE: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == ST_BIT && $past(st_r) == ST_START) |-> (sh_r == i2c_host_pkg::ADDR_WRITE))
        else $error("wrong write address byte");
    AST_READ_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == ST_BIT && $past(st_r) == ST_RSTART) |-> (sh_r == i2c_host_pkg::ADDR_READ && ph_r == PH_ADDR_R))
        else $error("wrong read address byte");
    AST_LAST_NACK: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == ST_ACK && scl_r && ph_r == PH_DATA && rd_r) |-> (sda_r == (len_r == 5'h01)))
        else $error("read acknowledge wrong");
    AST_RETRY: assert property (@(posedge sys_clk) disable iff (rst)
        ($rose(err_r) && try_r != 2'(RETRIES)) |-> ##[1:400] (st_r == ST_START))
        else $error("no retry after not-acknowledge");
endmodule

// ===== sensor_dev_model.sv
// Behavioural model of the sensor's two-wire register slave
module sensor_dev_model #(
    parameter logic [6:0] DEV_ADDR = 7'h57,
    parameter logic [7:0] FIFO_IDX = 8'h07
) (
    // Bus wires
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    // Scenario control and observation
    input wire logic nack_req,
    output logic [7:0] n_start,
    output logic [7:0] n_nack,
    output logic [7:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [256];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic [7:0] fifo_cnt = 8'h00;
    logic active = 1'b0;
    logic rd_mode = 1'b0;
    logic is_addr = 1'b0;
    logic is_idx = 1'b0;
    int bitn = 0;
    // Register bank starts from a known pattern the bench mirrors
    initial begin
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5A;
        sda_pull = 1'b0;
        n_start = 8'h00;
        n_nack = 8'h00;
        last_addr = 8'h00;
    end
    // Data falling with the clock high opens a transfer, also a repeated one
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            bitn = 0;
            is_addr = 1'b1;
            rd_mode = 1'b0;
            n_start = n_start + 8'h01;
        end
    end
    // Data rising with the clock high drops the transfer at any bit
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b0;
            sda_pull = 1'b0;
        end
    end
    // Sample on the rising clock; the address is compared bit by bit
    always @(posedge scl) begin
        if (active) begin
            if (bitn == 8) begin
                if (rd_mode && !is_addr && sda) active = 1'b0;
                bitn = 0;
            end else begin
                sh = {sh[6:0], sda};
                if (is_addr && bitn < 7 && sda !== DEV_ADDR[6 - bitn]) active = 1'b0;
                bitn = bitn + 1;
            end
        end
    end
    // Drive only while the clock is low; a released line floats to the pull-up
    always @(negedge scl) begin
        if (active) begin
            if (bitn == 8) begin
                if (is_addr) begin
                    last_addr = sh;
                    if (nack_req) begin
                        n_nack = n_nack + 8'h01;
                        active = 1'b0;
                        sda_pull = 1'b0;
                    end else begin
                        sda_pull = 1'b1;
                        rd_mode = sh[0];
                        is_idx = !sh[0];
                    end
                    is_addr = 1'b0;
                end else if (rd_mode) begin
                    sda_pull = 1'b0;
                end else begin
                    if (is_idx) ptr = sh;
                    else begin
                        regs[ptr] = sh;
                        ptr = ptr + 8'h01;
                    end
                    is_idx = 1'b0;
                    sda_pull = 1'b1;
                end
            end else if (rd_mode) begin
                if (bitn == 0) begin
                    tx = (ptr == FIFO_IDX) ? 8'hC0 + fifo_cnt : regs[ptr];
                    if (ptr == FIFO_IDX) fifo_cnt = fifo_cnt + 8'h01;
                    else ptr = ptr + 8'h01;
                end
                sda_pull = !tx[7 - bitn];
            end else begin
                sda_pull = 1'b0;
            end
        end
    end
endmodule

// ===== test_i2c_reg_host.sv
// Self-checking bench: register host against the sensor slave model
module test_i2c_reg_host;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QUARTER = 2;
    logic sys_clk = 1'b0;
    logic rst, cmd_valid, cmd_read, cmd_ready, wdata_valid, rdata_valid, done, nack_err;
    logic [7:0] cmd_index, wdata, rdata, n_start, n_nack, last_addr, exp_fifo, base, idx;
    logic [4:0] cmd_len;
    logic [3:0] wdata_addr;
    logic scl_o, scl_oe, sda_o, sda_oe, sda_pull, nack_req;
    logic [7:0] exp_regs [256];
    logic [7:0] got [$];
    int errors, n_checks, len;
    wire scl;
    wire sda;
    // Open-drain wires with pull-ups
    assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_oe && !sda_o) || sda_pull) ? 1'b0 : 1'b1;
    always #10 sys_clk = ~sys_clk;
    i2c_reg_host #(.QUARTER(QUARTER)) i2c_reg_host_inst (
        .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_index(cmd_index), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
        .wdata_valid(wdata_valid), .wdata_addr(wdata_addr), .wdata(wdata),
        .rdata_valid(rdata_valid), .rdata(rdata), .done(done), .nack_err(nack_err),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    sensor_dev_model sensor_dev_model_inst (
        .scl(scl), .sda(sda), .sda_pull(sda_pull), .nack_req(nack_req),
        .n_start(n_start), .n_nack(n_nack), .last_addr(last_addr));
    // Registered read stream: sampled at the edge, both outputs move together
    always @(posedge sys_clk) begin
        if (rdata_valid === 1'b1) got.push_back(rdata);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Next expected read byte; the pointer parks on the FIFO register
    function automatic logic [7:0] exp_byte(inout logic [7:0] p);
        logic [7:0] e;
        if (p == i2c_host_pkg::FIFO_DATA_INDEX) begin
            e = 8'hC0 + exp_fifo;
            exp_fifo = exp_fifo + 8'h01;
        end else begin
            e = exp_regs[p];
            p = p + 8'h01;
        end
        return e;
    endfunction
    task automatic wait_ready();
        for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (cmd_ready !== 1'b1) begin
            errors++;
            results();
        end
    endtask
    // One command; the bound covers four attempts of the longest burst
    task automatic run_cmd(input logic rd, input logic [7:0] ix, input int n);
        wait_ready();
        got.delete();
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_index <= ix;
        cmd_len <= 5'(n);
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        for (int i = 0; i < 8000 && done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (done !== 1'b1) begin
            errors++;
            results();
        end
        check({scl, sda}, 2'b11);
    endtask
    task automatic do_write(input logic [7:0] ix, input int n, input logic ok);
        logic [7:0] v;
        wait_ready();
        for (int k = 0; k < n; k++) begin
            v = 8'($urandom);
            @(posedge sys_clk);
            wdata_valid <= 1'b1;
            wdata_addr <= 4'(k);
            wdata <= v;
            if (ok) exp_regs[8'(ix + k)] = v;
        end
        @(posedge sys_clk);
        wdata_valid <= 1'b0;
        run_cmd(1'b0, ix, n);
        check(last_addr, 8'hAE);
        check(nack_err, !ok);
    endtask
    task automatic do_read(input logic [7:0] ix, input int n);
        logic [7:0] p;
        p = ix;
        run_cmd(1'b1, ix, n);
        check(last_addr, 8'hAF);
        check(got.size(), n);
        for (int k = 0; k < n && k < got.size(); k++) check(got[k], exp_byte(p));
    endtask
    initial begin
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        {cmd_valid, cmd_read, wdata_valid, nack_req} = 4'h0;
        {cmd_index, wdata, wdata_addr, cmd_len} = 25'h0;
        exp_fifo = 8'h00;
        for (int i = 0; i < 256; i++) exp_regs[i] = 8'(i) ^ 8'h5A;
        void'($urandom(32'h2E21));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        // Corners: longest and shortest bursts, top index 0xFF, read into the FIFO register
        do_write(8'h00, 16, 1'b1);
        do_read(8'h00, 16);
        do_write(8'hFF, 1, 1'b1);
        do_read(8'hFF, 1);
        do_read(8'h04, 9);
        repeat (6) begin
            idx = 8'($urandom);
            len = $urandom_range(1, 16);
            do_write(idx, len, 1'b1);
            do_read(idx, len);
        end
        // Out-of-range lengths must not start a transfer
        got.delete();
        for (int b = 0; b < 2; b++) begin
            base = n_start;
            @(posedge sys_clk);
            cmd_valid <= 1'b1;
            cmd_len <= b ? 5'h11 : 5'h00;
            repeat (40) @(posedge sys_clk);
            cmd_valid <= 1'b0;
            #1;
            check(n_start, base);
            check(cmd_ready, 1'b1);
        end
        // First address refused, the retry goes through
        base = n_nack;
        nack_req <= 1'b1;
        fork
            do_write(8'h20, 4, 1'b1);
            begin
                for (int i = 0; i < 3000 && n_nack == base; i++) @(posedge sys_clk);
                nack_req <= 1'b0;
            end
        join
        do_read(8'h20, 4);
        // Every attempt refused: error reported, registers untouched
        nack_req <= 1'b1;
        do_write(8'h30, 2, 1'b0);
        nack_req <= 1'b0;
        do_read(8'h30, 2);
        results();
    end
endmodule
